// *** pepc_defines.vh ***
`ifndef PEPC_DEFINES_VH
`define PEPC_DEFINES_VH
`define PEPC_ADDR_W 32
`define PEPC_OFF_P1_DATA 32'hFFFFF002
`define PEPC_OFF_P2_DATA 32'hFFFFF004
`define PEPC_OFF_P1_DIR 32'hFFFFF022
`define PEPC_OFF_P2_DIR 32'hFFFFF024
`define PEPC_OFF_P1_PU 32'hFFFFF0A2
`define PEPC_OFF_P2_PU 32'hFFFFF0A4
`define PEPC_OFF_P1_OD 32'h0FFFF0B0
`define PEPC_OFF_P2_OD 32'hFFFFF0B2
`define PEPC_OFF_RISE 32'hFFFFF0C0
`define PEPC_OFF_FALL 32'h0FFFF0C2
`define PEPC_RST_P1_DIR 8'h3F
`define PEPC_RST_P2_DIR 8'hFF
`define PEPC_RST_ZERO 8'h00
`define PEPC_P1_MASK 8'h3F
`define PEPC_P1_OD_MASK 8'h37
`define PEPC_P2_OD_MASK 8'h37
`define PEPC_FILT_SAMPLES 3
`endif

// *** pepc_noise_filter.v ***
`timescale 1ns/1ps
// Accepts a new level after SAMPLES equal consecutive samples
module pepc_noise_filter #(
	parameter SAMPLES = 3
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire enable_i,
	input wire pin_i,
	output reg level_o
);
	reg [SAMPLES-2:0] hist;
	wire [SAMPLES-1:0] window;
	// The live pin is the newest sample, so only SAMPLES-1 are stored
	assign window = {hist, pin_i};
	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			hist <= {(SAMPLES-1){1'b0}};
			level_o <= 1'b0;
		end
		else if (enable_i)
		begin
			hist <= window[SAMPLES-2:0];
			if (&window)
				level_o <= 1'b1;
			else if (~|window)
				level_o <= 1'b0;
		end
	end
endmodule

// *** pepc_edge_detect.v ***
`timescale 1ns/1ps
module pepc_edge_detect (
	input wire clock_i,
	input wire reset_n_i,
	input wire enable_i,
	input wire pin_i,
	input wire rise_en_i,
	input wire fall_en_i,
	output wire req_o
);
	reg prev;
	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			prev <= 1'b0;
		else if (enable_i)
			prev <= pin_i;
	end
	// Held low while clock enable is low so no request repeats
	assign req_o = enable_i & ((rise_en_i & pin_i & ~prev) | (fall_en_i & ~pin_i & prev));
endmodule

// *** pepc_port_group.v ***
`timescale 1ns/1ps
`include "pepc_defines.vh"
module pepc_port_group #(
	parameter FILT_SAMPLES = `PEPC_FILT_SAMPLES
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire clk_en_i,
	input wire [31:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire bit_access_i,
	input wire [2:0] bit_sel_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	input wire nmi_pin_i,
	input wire [6:0] ext_irq_pin_i,
	output wire nmi_req_o,
	output wire [6:0] ext_irq_req_o,
	input wire [5:0] p1_pin_i,
	output wire [5:0] p1_pin_o,
	output wire [5:0] p1_pin_oe_n_o,
	output wire [5:0] p1_pullup_o,
	input wire [5:0] p1_alt_out_i,
	input wire [7:0] p2_pin_i,
	output wire [7:0] p2_pin_o,
	output wire [7:0] p2_pin_oe_n_o,
	output wire [7:0] p2_pullup_o,
	input wire [7:0] p2_alt_out_i,
	output wire timer_input_two_o,
	output wire timer_input_three_o
);
	reg [7:0] falling_edge_select;
	reg [7:0] rising_edge_select;
	reg [7:0] port1_data_latch;
	reg [7:0] port1_direction;
	reg [7:0] port1_pullup_enable;
	reg [7:0] port1_open_drain_select;
	reg [7:0] port2_data_latch;
	reg [7:0] port2_direction;
	reg [7:0] port2_pullup_enable;
	reg [7:0] port2_open_drain_select;
	reg [7:0] cur;
	reg [7:0] next_val;
	reg hit;
	wire [7:0] p1_pins8;
	wire [7:0] p1_read;
	wire [7:0] p2_read;
	wire [7:0] p1_drive;
	wire [7:0] p2_drive;
	wire [7:0] irq_pins;
	wire [7:0] irq_req;
	wire wr_en;
	wire sel_p1_data;
	wire sel_p2_data;
	wire sel_p1_dir;
	wire sel_p2_dir;
	wire sel_p1_pu;
	wire sel_p2_pu;
	wire sel_p1_od;
	wire sel_p2_od;
	wire sel_rise;
	wire sel_fall;
	wire [7:0] next_port1_data_latch;
	wire [7:0] next_port2_data_latch;
	wire [7:0] next_port1_direction;
	wire [7:0] next_port2_direction;
	wire [7:0] next_port1_pullup_enable;
	wire [7:0] next_port2_pullup_enable;
	wire [7:0] next_port1_open_drain_select;
	wire [7:0] next_port2_open_drain_select;
	wire [7:0] next_rising_edge_select;
	wire [7:0] next_falling_edge_select;

	assign p1_pins8 = {2'b00, p1_pin_i};
	// Input bits show the pin, output bits the latch
	assign p1_read = ((p1_pins8 & port1_direction) | (port1_data_latch & ~port1_direction))
		& `PEPC_P1_MASK;
	assign p2_read = (p2_pin_i & port2_direction) | (port2_data_latch & ~port2_direction);

	assign wr_en = clk_en_i & wr_i;
	assign sel_p1_data = (addr_i == `PEPC_OFF_P1_DATA);
	assign sel_p2_data = (addr_i == `PEPC_OFF_P2_DATA);
	assign sel_p1_dir = (addr_i == `PEPC_OFF_P1_DIR);
	assign sel_p2_dir = (addr_i == `PEPC_OFF_P2_DIR);
	assign sel_p1_pu = (addr_i == `PEPC_OFF_P1_PU);
	assign sel_p2_pu = (addr_i == `PEPC_OFF_P2_PU);
	assign sel_p1_od = (addr_i == `PEPC_OFF_P1_OD);
	assign sel_p2_od = (addr_i == `PEPC_OFF_P2_OD);
	assign sel_rise = (addr_i == `PEPC_OFF_RISE);
	assign sel_fall = (addr_i == `PEPC_OFF_FALL);

	// Unimplemented bits are masked on the way in so they always read zero
	assign next_port1_data_latch = next_val & `PEPC_P1_MASK;
	assign next_port2_data_latch = next_val;
	assign next_port1_direction = next_val & `PEPC_P1_MASK;
	assign next_port2_direction = next_val;
	assign next_port1_pullup_enable = next_val & `PEPC_P1_MASK;
	assign next_port2_pullup_enable = next_val;
	assign next_port1_open_drain_select = next_val & `PEPC_P1_OD_MASK;
	assign next_port2_open_drain_select = next_val & `PEPC_P2_OD_MASK;
	assign next_rising_edge_select = next_val;
	assign next_falling_edge_select = next_val;

	// Current value of addressed register for bit merges and reads
	always @*
	begin
		hit = 1'b1;
		case (addr_i)
			`PEPC_OFF_P1_DATA: cur = p1_read;
			`PEPC_OFF_P2_DATA: cur = p2_read;
			`PEPC_OFF_P1_DIR: cur = port1_direction;
			`PEPC_OFF_P2_DIR: cur = port2_direction;
			`PEPC_OFF_P1_PU: cur = port1_pullup_enable;
			`PEPC_OFF_P2_PU: cur = port2_pullup_enable;
			`PEPC_OFF_P1_OD: cur = port1_open_drain_select;
			`PEPC_OFF_P2_OD: cur = port2_open_drain_select;
			`PEPC_OFF_RISE: cur = rising_edge_select;
			`PEPC_OFF_FALL: cur = falling_edge_select;
			default:
			begin
				cur = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	// Bit writes modify one bit; a read-modify of data uses the latch
	// for unselected bits so input pin levels never leak into it
	always @*
	begin
		if (addr_i == `PEPC_OFF_P1_DATA)
			next_val = port1_data_latch;
		else if (addr_i == `PEPC_OFF_P2_DATA)
			next_val = port2_data_latch;
		else
			next_val = cur;
		if (bit_access_i)
			next_val[bit_sel_i] = wdata_i[0];
		else
			next_val = wdata_i;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			falling_edge_select <= `PEPC_RST_ZERO;
		else if (wr_en && sel_fall)
			falling_edge_select <= next_falling_edge_select;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rising_edge_select <= `PEPC_RST_ZERO;
		else if (wr_en && sel_rise)
			rising_edge_select <= next_rising_edge_select;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port1_data_latch <= `PEPC_RST_ZERO;
		else if (wr_en && sel_p1_data)
			port1_data_latch <= next_port1_data_latch;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port1_direction <= `PEPC_RST_P1_DIR;
		else if (wr_en && sel_p1_dir)
			port1_direction <= next_port1_direction;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port1_pullup_enable <= `PEPC_RST_ZERO;
		else if (wr_en && sel_p1_pu)
			port1_pullup_enable <= next_port1_pullup_enable;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port1_open_drain_select <= `PEPC_RST_ZERO;
		else if (wr_en && sel_p1_od)
			port1_open_drain_select <= next_port1_open_drain_select;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port2_data_latch <= `PEPC_RST_ZERO;
		else if (wr_en && sel_p2_data)
			port2_data_latch <= next_port2_data_latch;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port2_direction <= `PEPC_RST_P2_DIR;
		else if (wr_en && sel_p2_dir)
			port2_direction <= next_port2_direction;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port2_pullup_enable <= `PEPC_RST_ZERO;
		else if (wr_en && sel_p2_pu)
			port2_pullup_enable <= next_port2_pullup_enable;
	end

	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port2_open_drain_select <= `PEPC_RST_ZERO;
		else if (wr_en && sel_p2_od)
			port2_open_drain_select <= next_port2_open_drain_select;
	end

	// Read data registered; unmapped reads return zero
	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_o <= 8'h00;
		else if (clk_en_i && rd_i)
		begin
			if (bit_access_i)
				rdata_o <= {7'h00, cur[bit_sel_i]};
			else
				rdata_o <= hit ? cur : 8'h00;
		end
	end

	// Alternate outputs ORed into the latch; software keeps latch at 0
	assign p1_drive = port1_data_latch | {2'b00, p1_alt_out_i};
	assign p2_drive = port2_data_latch | p2_alt_out_i;

	// Open-drain bits release instead of driving high
	assign p1_pin_o = p1_drive[5:0];
	assign p1_pin_oe_n_o = port1_direction[5:0]
		| (port1_open_drain_select[5:0] & p1_drive[5:0]);
	assign p1_pullup_o = port1_pullup_enable[5:0];
	assign p2_pin_o = p2_drive;
	assign p2_pin_oe_n_o = port2_direction
		| (port2_open_drain_select & p2_drive);
	assign p2_pullup_o = port2_pullup_enable;

	// Timer inputs pass the sampling noise filter
	pepc_noise_filter #(
		.SAMPLES(FILT_SAMPLES)
	) u_filt_ti2 (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.enable_i(clk_en_i),
		.pin_i(p2_pin_i[6]),
		.level_o(timer_input_two_o)
	);

	pepc_noise_filter #(
		.SAMPLES(FILT_SAMPLES)
	) u_filt_ti3 (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.enable_i(clk_en_i),
		.pin_i(p2_pin_i[7]),
		.level_o(timer_input_three_o)
	);

	assign irq_pins = {ext_irq_pin_i, nmi_pin_i};

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : g_edge
			pepc_edge_detect u_edge (
				.clock_i(clock_i),
				.reset_n_i(reset_n_i),
				.enable_i(clk_en_i),
				.pin_i(irq_pins[g]),
				.rise_en_i(rising_edge_select[g]),
				.fall_en_i(falling_edge_select[g]),
				.req_o(irq_req[g])
			);
		end
	endgenerate

	assign nmi_req_o = irq_req[0];
	assign ext_irq_req_o = irq_req[7:1];
endmodule

// *** pepc_pad_model.sv ***
`timescale 1ns/1ps
module pepc_pad_model (
	input wire [5:0] drv_i,
	input wire [5:0] oe_n_i,
	input wire [5:0] pu_i,
	input wire [5:0] ext_i,
	input wire [5:0] ext_en_i,
	output wire [5:0] pin_o
);
	// A floating pad without pull-up reads inverted, so a stale drive never passes
	assign pin_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_i)
		| (oe_n_i & ~ext_en_i & (pu_i | ~drv_i));
endmodule

// *** pepc_port_group_checker.sv ***
`timescale 1ns/1ps
`include "pepc_defines.vh"
module pepc_port_group_checker (
	input wire clock_i,
	input wire reset_n_i,
	input wire clk_en_i,
	input wire [31:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire bit_access_i,
	input wire [7:0] wdata_i,
	input wire [7:0] rdata_o,
	input wire nmi_pin_i,
	input wire [6:0] ext_irq_pin_i,
	input wire nmi_req_o,
	input wire [6:0] ext_irq_req_o,
	input wire [5:0] p1_pin_o,
	input wire [5:0] p1_pin_oe_n_o,
	input wire [5:0] p1_alt_out_i,
	input wire [7:0] p2_pin_i,
	input wire [7:0] p2_pin_o,
	input wire [7:0] p2_alt_out_i,
	input wire timer_input_two_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	wire dir_wr = wr_i && clk_en_i && !bit_access_i && addr_i == `PEPC_OFF_P1_DIR;
	a_nmi_edge_req: assert property (nmi_req_o |-> nmi_pin_i != $past(nmi_pin_i))
		else $error("nmi request without edge");
	a_ext_edge_req: assert property ((ext_irq_req_o & ~(ext_irq_pin_i ^ $past(ext_irq_pin_i))) == 7'h00)
		else $error("pin request without edge");
	a_p1_alt_or: assert property ((p1_alt_out_i & ~p1_pin_o) == 6'h00)
		else $error("port one output lost alternate");
	a_p2_alt_or: assert property ((p2_alt_out_i & ~p2_pin_o) == 8'h00)
		else $error("port two output lost alternate");
	a_rdata_hold: assert property (!(rd_i && clk_en_i) |=> $stable(rdata_o))
		else $error("read data moved without read");
	a_dir_input: assert property (dir_wr |=> (p1_pin_oe_n_o | ~$past(wdata_i[5:0])) == 6'h3F)
		else $error("input bit still driven");
	a_dir_output: assert property (dir_wr |=> (p1_pin_oe_n_o & ~$past(wdata_i[5:0]) & ~p1_pin_o) == 6'h00)
		else $error("output low not driven");
	a_filter_three: assert property ($changed(timer_input_two_o) |-> $past(p2_pin_i[6]) == timer_input_two_o
		&& $past(p2_pin_i[6], 2) == timer_input_two_o && $past(p2_pin_i[6], 3) == timer_input_two_o)
		else $error("filter took short level");
endmodule
bind pepc_port_group pepc_port_group_checker pepc_port_group_checker_i (.*);

// *** pepc_port_group_test.sv ***
`timescale 1ns/1ps
`include "pepc_defines.vh"
module pepc_port_group_test;
	logic clock_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic clk_en_i = 1'h1;
	logic wr_i = 1'h0;
	logic rd_i = 1'h0;
	logic bit_access_i = 1'h0;
	logic nmi_pin_i = 1'h1;
	logic [2:0] bit_sel_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [31:0] addr_i = 32'h0;
	logic [6:0] ext_irq_pin_i = 7'h7F;
	logic [5:0] p1_alt_out_i = 6'h00;
	logic [5:0] pad_ext = 6'h2A;
	logic [5:0] pad_ext_en = 6'h3F;
	logic [7:0] p2_alt_out_i = 8'h00;
	logic [7:0] p2_pin_i = 8'h05;
	wire [7:0] rdata_o, p2_pin_o, p2_pin_oe_n_o, p2_pullup_o;
	wire [6:0] ext_irq_req_o;
	wire [5:0] p1_pin_i, p1_pin_o, p1_pin_oe_n_o, p1_pullup_o;
	wire nmi_req_o, timer_input_two_o, timer_input_three_o;
	int fail_count = 0;
	int check_count = 0;
	int tn = 0;
	always #12.5 clock_i = ~clock_i;
	pepc_port_group pepc_port_group_i (.*);
	pepc_pad_model pepc_pad_model_i (.drv_i(p1_pin_o), .oe_n_i(p1_pin_oe_n_o), .pu_i(p1_pullup_o),
		.ext_i(pad_ext), .ext_en_i(pad_ext_en), .pin_o(p1_pin_i));
	task chk(input [7:0] s, input [7:0] e);
		check_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t saw %h want %h", $time, s, e);
		end
	endtask
	task acc(input w, input [31:0] a, input [7:0] d, input b = 1'h0, input [2:0] s = 3'h0);
		@(negedge clock_i);
		addr_i = a;
		wdata_i = d;
		bit_access_i = b;
		bit_sel_i = s;
		wr_i = w;
		rd_i = !w;
		@(negedge clock_i);
		wr_i = 1'h0;
		rd_i = 1'h0;
	endtask
	task rd(input [31:0] a, input [7:0] e, input b = 1'h0, input [2:0] s = 3'h0);
		acc(1'h0, a, 8'h00, b, s);
		chk(rdata_o, e);
	endtask
	task done;
		tn++;
		$display("test %0d done", tn);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task pins(input [7:0] v, input [7:0] e);
		@(negedge clock_i);
		{ext_irq_pin_i, nmi_pin_i} = v;
		#1 chk({ext_irq_req_o, nmi_req_o}, e);
	endtask
	initial
	begin
		#100000;
		fail_count++;
		final_report;
	end
	initial
	begin
		repeat (5) @(posedge clock_i);
		@(negedge clock_i);
		reset_n_i = 1'h1;
		chk({p1_pullup_o, p1_pin_oe_n_o[5:4]}, 8'h03);
		chk(p2_pin_oe_n_o, 8'hFF);
		rd(`PEPC_OFF_P1_DIR, 8'h3F);
		rd(`PEPC_OFF_FALL, 8'h00);
		rd(`PEPC_OFF_RISE, 8'h00);
		rd(`PEPC_OFF_P1_PU, 8'h00);
		rd(`PEPC_OFF_P1_OD, 8'h00);
		rd(`PEPC_OFF_P2_DATA, 8'h05);
		acc(1'h1, `PEPC_OFF_P2_DIR, 8'h00);
		rd(`PEPC_OFF_P2_DATA, 8'h00);
		acc(1'h1, `PEPC_OFF_P2_OD, 8'hFF);
		rd(`PEPC_OFF_P2_OD, 8'h37);
		acc(1'h1, `PEPC_OFF_P2_PU, 8'hA5);
		chk(p2_pullup_o, 8'hA5);
		acc(1'h1, `PEPC_OFF_P2_DIR, 8'hFF);
		rd(32'h0, 8'h00);
		done;
		acc(1'h1, `PEPC_OFF_P1_DATA, 8'h15);
		rd(`PEPC_OFF_P1_DATA, 8'h2A);
		chk({2'h0, p1_pin_oe_n_o}, 8'h3F);
		pad_ext_en = 6'h00;
		acc(1'h1, `PEPC_OFF_P1_DIR, 8'hFF);
		rd(`PEPC_OFF_P1_DIR, 8'h3F);
		acc(1'h1, `PEPC_OFF_P1_DIR, 8'h00);
		chk({2'h0, p1_pin_o}, 8'h15);
		acc(1'h1, `PEPC_OFF_P1_DATA, 8'h01, 1'h1, 3'h1);
		rd(`PEPC_OFF_P1_DATA, 8'h17);
		rd(`PEPC_OFF_P1_DATA, 8'h01, 1'h1, 3'h1);
		acc(1'h1, `PEPC_OFF_P1_DIR, 8'h01, 1'h1, 3'h5);
		rd(`PEPC_OFF_P1_DIR, 8'h20);
		rd(`PEPC_OFF_P1_DATA, 8'h37);
		done;
		acc(1'h1, `PEPC_OFF_P1_DIR, 8'h00);
		acc(1'h1, `PEPC_OFF_P1_OD, 8'hFF);
		rd(`PEPC_OFF_P1_OD, 8'h37);
		acc(1'h1, `PEPC_OFF_P1_DATA, 8'h3F);
		chk({2'h0, p1_pin_oe_n_o}, 8'h37);
		acc(1'h1, `PEPC_OFF_P1_OD, 8'h00);
		acc(1'h1, `PEPC_OFF_P1_DATA, 8'h00);
		p1_alt_out_i = 6'h2C;
		p2_alt_out_i = 8'hC3;
		#1 chk({2'h0, p1_pin_o}, 8'h2C);
		chk(p2_pin_o, 8'hC3);
		acc(1'h1, `PEPC_OFF_P1_PU, 8'hFF);
		rd(`PEPC_OFF_P1_PU, 8'h3F);
		chk({2'h0, p1_pullup_o}, 8'h3F);
		done;
		acc(1'h1, `PEPC_OFF_FALL, 8'hA6);
		pins(8'h00, 8'hA6);
		pins(8'hFF, 8'h00);
		acc(1'h1, `PEPC_OFF_FALL, 8'h00, 1'h1, 3'h1);
		rd(`PEPC_OFF_FALL, 8'hA4);
		acc(1'h1, `PEPC_OFF_FALL, 8'h00);
		acc(1'h1, `PEPC_OFF_RISE, 8'h5B);
		pins(8'h00, 8'h00);
		pins(8'hFF, 8'h5B);
		done;
		p2_pin_i = 8'hC5;
		repeat (2) @(negedge clock_i);
		p2_pin_i = 8'h05;
		repeat (4) @(negedge clock_i);
		chk({6'h00, timer_input_three_o, timer_input_two_o}, 8'h00);
		p2_pin_i = 8'hC5;
		repeat (4) @(negedge clock_i);
		chk({6'h00, timer_input_three_o, timer_input_two_o}, 8'h03);
		reset_n_i = 1'h0;
		@(negedge clock_i);
		chk({2'h0, p1_pin_oe_n_o}, 8'h3F);
		reset_n_i = 1'h1;
		rd(`PEPC_OFF_RISE, 8'h00);
		done;
		final_report;
	end
endmodule
